// ### hdl/char_display_command_decoder.sv
// command decoder for a two-line, 40-character text display
// assumes byte strobes arrive synchronous to clk from the host bus logic
`timescale 1ns/1ps

// Summary of operation
// - clear writes 20H to every text address, zeroes counter, selects text memory.
// - clear also zeroes shift, homes cursor, forces increment mode.
// - home zeroes counter, selects text memory, zeroes shift.
// - entry mode stores direction; counter steps up or down per access.
// - shift-enable makes text writes shift display opposite direction.
// - text reads and any glyph access move only the cursor.
// - every display shift moves both lines together by one.
// - on/off bit 2 enables the whole display.
// - display off inhibits the power converter.
// - on/off bit 1 shows or hides the cursor.
// - on/off bit 0 blinks the cursor character at about 1 Hz.
// - shift command moves cursor, optionally with display, left or right.
// - function-set bit 4 picks 8-bit or 4-bit transfers.
// - data byte after function-set sets brightness from two low bits.
// - command after function-set cancels brightness wait.
// - glyph-address command loads six bits, selects glyph memory.
// - glyph counter is six bits and wraps.
// - text-address command loads seven bits, selects text memory.
// - counter updates after each access following the direction.
// - busy high while an instruction executes.
// - 4-bit mode pairs high nibble then low nibble on writes; reads take one strobe.
// - power-on performs clear and default settings.
module char_display_command_decoder
	import char_display_pkg::*;
#(
	parameter int CLEAR_COUNT = CLEAR_CYCLES,
	parameter int BLINK_COUNT = BLINK_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       byteStrobe,
	input  wire logic [7:0] busData,
	input  wire logic       command_or_data_select,
	input  wire logic       readAccess,
	output logic            busy_flag,
	output logic [6:0]      address_counter_value,
	output logic            glyphSelect,
	output logic [5:0]      shiftOffset,
	output logic            incrementMode,
	output logic            shiftEnable,
	output logic            displayOn,
	output logic            converterInhibit,
	output logic            cursorOn,
	output logic            blinkOn,
	output logic            blinkPhase,
	output logic            wideBus,
	output logic            brightness_level_high,
	output logic            brightness_level_low,
	output logic            memWrite,
	output logic [6:0]      memAddr,
	output logic [7:0]      memData
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	state_e      state, next_state;
	logic [6:0]  next_acc;
	logic        next_glyph, next_dir, next_sen, next_disp, next_cur, next_blink, next_wide;
	logic [5:0]  next_shift;
	logic [1:0]  bright, next_bright;
	logic        brightWait, next_brightWait;
	logic        nibbleHalf, next_nibbleHalf;
	logic [3:0]  nibbleHigh, next_nibbleHigh;
	logic [15:0] waitCnt, next_waitCnt;
	logic        next_memWrite;
	logic [6:0]  next_memAddr;
	logic [7:0]  next_memData;
	logic [25:0] blinkCnt, next_blinkCnt;
	logic        next_blinkPhase;
	logic        byteValid;
	logic [7:0]  byteVal;

	// step the counter one place; glyph space wraps at six bits
	function automatic logic [6:0] stepAddr(input logic [6:0] a, input logic up,
		input logic glyph);
		logic [6:0] r;
		r = up ? a + 7'h01 : a - 7'h01;
		if (glyph) begin
			r = r & GLYPH_MASK;
		end
		return r;
	endfunction

	// ----------------------------------------
	// byte assembly
	// ----------------------------------------
	// high nibble first, then low nibble on the upper lines
	always_comb begin
		byteValid = 1'b0;
		byteVal = busData;
		next_nibbleHalf = nibbleHalf;
		next_nibbleHigh = nibbleHigh;
		if (byteStrobe && !readAccess && !wideBus) begin
			if (!nibbleHalf) begin
				next_nibbleHalf = 1'b1;
				next_nibbleHigh = busData[7:4];
			end else begin
				next_nibbleHalf = 1'b0;
				byteValid = 1'b1;
				byteVal = {nibbleHigh, busData[7:4]};
			end
		end else if (byteStrobe) begin
			byteValid = 1'b1;
		end
	end

	// ----------------------------------------
	// decoder
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_acc = address_counter_value;
		next_glyph = glyphSelect;
		next_shift = shiftOffset;
		next_dir = incrementMode;
		next_sen = shiftEnable;
		next_disp = displayOn;
		next_cur = cursorOn;
		next_blink = blinkOn;
		next_wide = wideBus;
		next_bright = bright;
		next_brightWait = brightWait;
		next_waitCnt = waitCnt;
		next_memWrite = 1'b0;
		next_memAddr = memAddr;
		next_memData = memData;
		case (state)
			ST_CLEAR: begin
				// sweep blank code over text memory, address 0 first
				next_memWrite = 1'b1;
				next_memAddr = memWrite ? memAddr + 7'h01 : ADDR_RESET;
				next_memData = BLANK_CODE;
				if (memWrite && memAddr == 7'(TEXT_DEPTH - 1)) begin
					next_memWrite = 1'b0;
					next_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// busy held until the count expires
				if (waitCnt <= 16'h0001) begin
					next_state = ST_IDLE;
				end
				next_waitCnt = waitCnt - 16'h0001;
			end
			ST_IDLE: begin
				if (byteValid && command_or_data_select) begin
					// brightness byte straight after function set
					if (brightWait && !readAccess) begin
						next_bright = byteVal[1:0];
						next_brightWait = 1'b0;
					end else begin
						next_brightWait = 1'b0;
						next_memWrite = !readAccess;
						next_memAddr = address_counter_value;
						next_memData = byteVal;
						// counter follows direction after each access
						next_acc = stepAddr(address_counter_value, incrementMode, glyphSelect);
						// shift display opposite direction, cursor held
						// reads and glyph accesses never shift the display
						if (shiftEnable && !readAccess && !glyphSelect) begin
							// one offset shared by both lines
							next_shift = incrementMode ? shiftOffset + 6'h01 : shiftOffset - 6'h01;
						end
					end
				end else if (byteValid && !readAccess) begin
					next_brightWait = 1'b0;
					next_state = ST_WAIT;
					next_waitCnt = 16'(SHORT_CYCLES);
					if (byteVal[BIT_TEXT_ADDR]) begin
						next_acc = byteVal[6:0];
						next_glyph = 1'b0;
					end else if (byteVal[BIT_GLYPH_ADDR]) begin
						// glyph space masked to six bits
						next_acc = byteVal[6:0] & GLYPH_MASK;
						next_glyph = 1'b1;
					end else if (byteVal[BIT_FUNC]) begin
						next_wide = byteVal[POS_WIDTH];
						next_brightWait = 1'b1;
					end else if (byteVal[BIT_SHIFT]) begin
						// move cursor, with display when selected
						next_acc = stepAddr(address_counter_value, byteVal[POS_RL], glyphSelect);
						if (byteVal[POS_SC]) begin
							next_shift = byteVal[POS_RL] ? shiftOffset - 6'h01 : shiftOffset + 6'h01;
						end
					end else if (byteVal[BIT_ONOFF]) begin
						next_disp = byteVal[POS_DISP];
						next_cur = byteVal[POS_CURSOR];
						next_blink = byteVal[POS_BLINK];
					end else if (byteVal[BIT_ENTRY]) begin
						next_dir = byteVal[POS_DIR];
						next_sen = byteVal[POS_SHIFT_EN];
					end else if (byteVal[BIT_HOME]) begin
						next_acc = ADDR_RESET;
						next_glyph = 1'b0;
						next_shift = SHIFT_RESET;
					end else if (byteVal == CMD_CLEAR) begin
						// counter to zero on text memory
						next_acc = ADDR_RESET;
						next_glyph = 1'b0;
						next_shift = SHIFT_RESET;
						next_dir = 1'b1;
						next_state = ST_CLEAR;
						next_memAddr = ADDR_RESET;
						next_waitCnt = 16'(CLEAR_COUNT - TEXT_DEPTH);
					end else begin
						next_state = ST_IDLE;
					end
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// about 1 Hz blink, half period each phase
	always_comb begin
		next_blinkCnt = blinkCnt + 26'h1;
		next_blinkPhase = blinkPhase;
		if (!blinkOn) begin
			next_blinkCnt = 26'h0;
			next_blinkPhase = 1'b0;
		end else if (blinkCnt == 26'(BLINK_COUNT - 1)) begin
			next_blinkCnt = 26'h0;
			next_blinkPhase = !blinkPhase;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// power-on clear and defaults
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_CLEAR;
			address_counter_value <= ADDR_RESET;
			glyphSelect <= 1'b0;
			shiftOffset <= SHIFT_RESET;
			incrementMode <= DIR_RESET;
			shiftEnable <= 1'b0;
			displayOn <= 1'b0;
			cursorOn <= 1'b0;
			blinkOn <= 1'b0;
			wideBus <= WIDE_RESET;
			bright <= BRIGHT_RESET;
			brightWait <= 1'b0;
			nibbleHalf <= 1'b0;
			nibbleHigh <= 4'h0;
			waitCnt <= 16'h0001;
			memWrite <= 1'b0;
			memAddr <= ADDR_RESET;
			memData <= BLANK_CODE;
			blinkCnt <= 26'h0;
			blinkPhase <= 1'b0;
		end else begin
			state <= next_state;
			address_counter_value <= next_acc;
			glyphSelect <= next_glyph;
			shiftOffset <= next_shift;
			incrementMode <= next_dir;
			shiftEnable <= next_sen;
			displayOn <= next_disp;
			cursorOn <= next_cur;
			blinkOn <= next_blink;
			wideBus <= next_wide;
			bright <= next_bright;
			brightWait <= next_brightWait;
			nibbleHalf <= next_nibbleHalf;
			nibbleHigh <= next_nibbleHigh;
			waitCnt <= next_waitCnt;
			memWrite <= next_memWrite;
			memAddr <= next_memAddr;
			memData <= next_memData;
			blinkCnt <= next_blinkCnt;
			blinkPhase <= next_blinkPhase;
		end
	end

	assign busy_flag = (state != ST_IDLE);
	assign converterInhibit = !displayOn;
	assign brightness_level_high = bright[1];
	assign brightness_level_low = bright[0];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_CLEAR_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
		(state == ST_IDLE && byteValid && !command_or_data_select && !readAccess
		&& byteVal == CMD_CLEAR) |=> busy_flag && address_counter_value == ADDR_RESET
		&& !glyphSelect && incrementMode && shiftOffset == SHIFT_RESET)
		else $error("clear did not reset counter state");
	AST_INHIBIT: assert property (@(posedge clk) disable iff (!rst_n)
		(state == ST_IDLE && byteValid && !command_or_data_select && !readAccess
		&& byteVal[7:3] == 5'h01) |=> converterInhibit == !$past(byteVal[POS_DISP]))
		else $error("converter inhibit wrong");
	AST_GLYPH_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
		glyphSelect |-> address_counter_value[6] == 1'b0)
		else $error("glyph counter exceeded six bits");
	AST_BUSY_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
		(state == ST_WAIT && waitCnt == 16'h0001) |=> !busy_flag)
		else $error("busy did not drop");
	AST_SHIFT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		(state == ST_IDLE && byteValid && command_or_data_select && readAccess)
		|=> $stable(shiftOffset)) else $error("read shifted display");
	AST_BRIGHT_CANCEL: assert property (@(posedge clk) disable iff (!rst_n)
		(state == ST_IDLE && byteValid && !command_or_data_select && !readAccess
		&& byteVal[7:5] != 3'b001) |=> !brightWait && $stable(bright))
		else $error("brightness wait not cancelled");
	AST_ENTRY: assert property (@(posedge clk) disable iff (!rst_n)
		(state == ST_IDLE && byteValid && !command_or_data_select && !readAccess
		&& byteVal[7:2] == 6'h01) |=> incrementMode == $past(byteVal[POS_DIR]))
		else $error("direction not stored");
	AST_ONOFF: assert property (@(posedge clk) disable iff (!rst_n)
		(state == ST_IDLE && byteValid && !command_or_data_select && !readAccess
		&& byteVal[7:3] == 5'h01) |=> displayOn == $past(byteVal[POS_DISP])
		&& cursorOn == $past(byteVal[POS_CURSOR])) else $error("on/off not taken");

endmodule

// ### hdl/char_display_pkg.sv
// constants shared by the character display command decoder
// assumes a single 25 MHz clock domain
package char_display_pkg;

	localparam int          CLK_MHZ        = 25;
	// clear time in microseconds, longest figure
	localparam int          CLEAR_US       = 100;
	localparam int          CLEAR_CYCLES   = CLEAR_US * CLK_MHZ;
	// blink half period in milliseconds (about 1 Hz, 50% duty)
	localparam int          BLINK_HALF_MS  = 500;
	localparam int          BLINK_CYCLES   = BLINK_HALF_MS * 1000 * CLK_MHZ;
	// short instruction time in cycles (666 ns rounded up at 40 ns)
	localparam int          SHORT_NS       = 666;
	localparam int          SHORT_CYCLES   = (SHORT_NS + 39) / 40;

	localparam int          TEXT_DEPTH     = 128;
	localparam logic [7:0]  BLANK_CODE     = 8'h20;
	localparam logic [7:0]  CMD_CLEAR      = 8'h01;
	localparam logic [6:0]  ADDR_RESET     = 7'h00;
	localparam logic [6:0]  GLYPH_MASK     = 7'h3f;
	localparam logic [5:0]  SHIFT_RESET    = 6'h00;
	localparam logic [1:0]  BRIGHT_RESET   = 2'h0;
	localparam logic        DIR_RESET      = 1'b1;
	localparam logic        WIDE_RESET     = 1'b1;

	// command classes, by highest set bit
	localparam int          BIT_TEXT_ADDR  = 7;
	localparam int          BIT_GLYPH_ADDR = 6;
	localparam int          BIT_FUNC       = 5;
	localparam int          BIT_SHIFT      = 4;
	localparam int          BIT_ONOFF      = 3;
	localparam int          BIT_ENTRY      = 2;
	localparam int          BIT_HOME       = 1;

	// field positions
	localparam int          POS_DIR        = 1;
	localparam int          POS_SHIFT_EN   = 0;
	localparam int          POS_DISP       = 2;
	localparam int          POS_CURSOR     = 1;
	localparam int          POS_BLINK      = 0;
	localparam int          POS_SC         = 3;
	localparam int          POS_RL         = 2;
	localparam int          POS_WIDTH      = 4;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_CLEAR = 3'b010,
		ST_WAIT  = 3'b100
	} state_e;

endpackage

// ### testbench/char_display_command_decoder_tb.sv
// self-checking bench for the display command decoder
// assumes host_bus_model drives the byte interface
`timescale 1ns/1ps
module char_display_command_decoder_tb;
	import char_display_pkg::*;
	localparam int CLR = 200;
	logic       clk, rst_n, busy_flag, glyphSelect, incrementMode, shiftEnable;
	logic       displayOn, converterInhibit, cursorOn, blinkOn, blinkPhase, wideBus;
	logic       brightness_level_high, brightness_level_low, memWrite;
	logic       prevPhase;
	logic       byteStrobe, command_or_data_select, readAccess;
	logic [6:0] address_counter_value, memAddr, lastAddr;
	logic [5:0] shiftOffset;
	logic [7:0] busData, memData, lastData;
	int         fails, compares, writes, blanks, w0, t;

	char_display_command_decoder #(.CLEAR_COUNT(CLR), .BLINK_COUNT(8)) uut (
		.clk(clk), .rst_n(rst_n), .byteStrobe(byteStrobe), .busData(busData),
		.command_or_data_select(command_or_data_select), .readAccess(readAccess),
		.busy_flag(busy_flag), .address_counter_value(address_counter_value),
		.glyphSelect(glyphSelect), .shiftOffset(shiftOffset), .incrementMode(incrementMode),
		.shiftEnable(shiftEnable), .displayOn(displayOn), .converterInhibit(converterInhibit),
		.cursorOn(cursorOn), .blinkOn(blinkOn), .blinkPhase(blinkPhase), .wideBus(wideBus),
		.brightness_level_high(brightness_level_high),
		.brightness_level_low(brightness_level_low), .memWrite(memWrite),
		.memAddr(memAddr), .memData(memData));

	host_bus_model host (.clk(clk), .busy_flag(busy_flag), .byteStrobe(byteStrobe),
		.busData(busData), .command_or_data_select(command_or_data_select),
		.readAccess(readAccess));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// memory write port monitor
	always @(posedge clk) begin
		if (memWrite === 1'b1) begin
			writes++;
			blanks += (memData === BLANK_CODE) ? 1 : 0;
			lastAddr = memAddr;
			lastData = memData;
		end
	end

	task automatic cmp(input string name, input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic end_sim;
		if (fails == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic cmd(input logic [7:0] v);
		host.send(1'b0, 1'b0, v);
	endtask

	task automatic wr(input logic [7:0] v);
		host.send(1'b1, 1'b0, v);
	endtask

	task automatic ctr(input logic [6:0] a);
		cmp("counter", {1'b0, address_counter_value}, {1'b0, a});
	endtask

	task automatic sft(input logic [5:0] s);
		cmp("shiftOffset", {2'h0, shiftOffset}, {2'h0, s});
	endtask

	initial begin
		#(40 * 20000);
		fails++;
		end_sim();
	end

	// --------------------------------------------------
	// test sequence
	// --------------------------------------------------
	initial begin
		rst_n = 1'b0;
		fails = 0;
		compares = 0;
		writes = 0;
		blanks = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		cmp("busy", {7'h0, busy_flag}, 8'h01);
		repeat (CLR + 20) @(posedge clk);
		#1;
		cmp("powerOnBlanks", 8'(blanks), 8'h80);
		ctr(7'h00);
		cmp("modes", {glyphSelect, incrementMode, shiftEnable, displayOn, cursorOn, blinkOn,
			converterInhibit, wideBus}, 8'h43);
		cmp("bright", {6'h0, brightness_level_high, brightness_level_low}, 8'h00);
		cmd(8'h38);
		cmp("busy", {7'h0, busy_flag}, 8'h01);
		w0 = writes;
		wr(8'hf3);
		cmp("bright", {6'h0, brightness_level_high, brightness_level_low}, 8'h03);
		cmp("brightNoWrite", 8'(writes - w0), 8'h00);
		cmd(8'h30);
		cmd(8'h0c);
		cmp("bright", {6'h0, brightness_level_high, brightness_level_low}, 8'h03);
		for (int v = 8; v < 16; v++) begin
			cmd(8'(v));
			cmp("onOff", {4'h0, converterInhibit, displayOn, cursorOn, blinkOn},
				{4'h0, !v[2], 3'(v)});
		end
		t = 0;
		prevPhase = blinkPhase;
		repeat (64) begin
			@(posedge clk);
			#1;
			t += (blinkPhase !== prevPhase) ? 1 : 0;
			prevPhase = blinkPhase;
		end
		cmp("blinkToggles", {7'h0, t >= 7 && t <= 9}, 8'h01);
		cmd(8'h85);
		ctr(7'h05);
		cmd(8'h06);
		wr(8'h41);
		cmp("writeAddr", {1'b0, lastAddr}, 8'h05);
		cmp("writeData", lastData, 8'h41);
		ctr(7'h06);
		cmd(8'h04);
		wr(8'h42);
		ctr(7'h05);
		sft(6'h00);
		cmd(8'h07);
		wr(8'h43);
		ctr(7'h06);
		sft(6'h01);
		w0 = writes;
		host.send(1'b1, 1'b1, 8'h00);
		ctr(7'h07);
		sft(6'h01);
		cmp("readNoWrite", 8'(writes - w0), 8'h00);
		cmd(8'h18);
		sft(6'h02);
		cmd(8'h1c);
		sft(6'h01);
		cmd(8'h10);
		ctr(7'h06);
		cmd(8'h14);
		ctr(7'h07);
		cmd(8'h7f);
		ctr(7'h3f);
		cmp("glyphSel", {7'h0, glyphSelect}, 8'h01);
		wr(8'h1f);
		cmp("glyphAddr", {1'b0, lastAddr}, 8'h3f);
		ctr(7'h00);
		sft(6'h01);
		cmd(8'hc3);
		ctr(7'h43);
		cmd(8'h03);
		ctr(7'h00);
		sft(6'h00);
		cmp("glyphSel", {7'h0, glyphSelect}, 8'h00);
		cmd(8'h04);
		cmd(8'h18);
		cmd(8'hc5);
		w0 = writes;
		blanks = 0;
		cmd(8'h01);
		cmp("busy", {7'h0, busy_flag}, 8'h01);
		repeat (CLR + 20) @(posedge clk);
		#1;
		cmp("clearWrites", 8'(writes - w0), 8'h80);
		cmp("clearBlanks", 8'(blanks), 8'h80);
		ctr(7'h00);
		sft(6'h00);
		cmp("incr", {7'h0, incrementMode}, 8'h01);
		cmd(8'h20);
		cmp("wide", {7'h0, wideBus}, 8'h00);
		cmd(8'h94);
		ctr(7'h14);
		cmd(8'h30);
		cmp("wide", {7'h0, wideBus}, 8'h01);
		cmd(8'h05);
		wr(8'h44);
		ctr(7'h13);
		sft(6'h3f);
		cmd(8'h08);
		cmp("blinkPhase", {7'h0, blinkPhase}, 8'h00);
		end_sim();
	end
endmodule

// ### testbench/host_bus_model.sv
// host processor model: writes command and data bytes to the decoder
// assumes the decoder clock is shared and busy_flag is visible to the host
`timescale 1ns/1ps
module host_bus_model (
	input  wire logic       clk,
	input  wire logic       busy_flag,
	output logic            byteStrobe,
	output logic [7:0]      busData,
	output logic            command_or_data_select,
	output logic            readAccess
);
	logic fourBit;

	initial begin
		byteStrobe = 1'b0;
		busData = 8'h00;
		command_or_data_select = 1'b0;
		readAccess = 1'b0;
		fourBit = 1'b0;
	end

	// --------------------------------------------------
	// one strobe
	// --------------------------------------------------
	// strobes while busy are dropped, so wait for ready first
	task automatic strobe(input logic sel, input logic rd, input logic [7:0] val);
		int n;
		n = 0;
		@(posedge clk);
		while (busy_flag !== 1'b0 && n < 400) begin
			n++;
			@(posedge clk);
		end
		byteStrobe <= 1'b1;
		busData <= val;
		command_or_data_select <= sel;
		readAccess <= rd;
		@(posedge clk);
		byteStrobe <= 1'b0;
		// released bus shows junk, not the last value
		busData <= ~val;
		command_or_data_select <= ~sel;
		readAccess <= 1'b0;
	endtask

	// --------------------------------------------------
	// whole byte
	// --------------------------------------------------
	task automatic send(input logic sel, input logic rd, input logic [7:0] val);
		if (fourBit) begin
			strobe(sel, rd, {val[7:4], 4'ha});
			strobe(sel, rd, {val[3:0], 4'h5});
		end else begin
			strobe(sel, rd, val);
		end
		if (!sel && val[7:5] == 3'b001)
			fourBit = !val[4];
		@(posedge clk);
		#1;
	endtask
endmodule
